//--- bcgc_pkg.sv
// Package for the buffer configuration and global control register bank.
// Assumes an 8-bit register port driven by the local microcontroller.
package bcgc_pkg;
	localparam int unsigned  ADDR_W         = 8;
	localparam int unsigned  DATA_W         = 8;
	localparam logic [7:0]   OFF_BUF_CFG    = 8'h2A;
	localparam logic [7:0]   OFF_RSVD_LOW   = 8'h2B;
	localparam logic [7:0]   OFF_LAST_BLK   = 8'h2C;
	localparam logic [7:0]   OFF_RSVD_HIGH  = 8'h2D;
	localparam logic [7:0]   OFF_REFRESH    = 8'h2E;
	localparam logic [7:0]   OFF_GLOBAL     = 8'h2F;
	localparam logic [7:0]   RST_BYTE       = 8'h00;
	localparam int unsigned  BIT_OR_FMT     = 7;
	localparam int unsigned  BIT_DSEL       = 6;
	localparam int unsigned  BIT_SSEL       = 5;
	localparam int unsigned  BIT_CSEL       = 4;
	localparam int unsigned  BIT_BLK        = 3;
	localparam int unsigned  BIT_SLEEP      = 7;
	localparam int unsigned  BIT_SRST       = 6;
	localparam int unsigned  BIT_HBURST     = 5;
	localparam int unsigned  BIT_DBURST     = 4;
	localparam int unsigned  BIT_AUDIO_PORT = 3;
	localparam logic [11:0]  BLK_SMALL      = 12'hA00;
	localparam logic [11:0]  BLK_LARGE      = 12'hC00;
	localparam logic [7:0]   REFRESH_UNIT   = 8'h10;

	typedef enum logic [1:0] {
		BCGC_DEC_STOP,
		BCGC_DEC_MONITOR,
		BCGC_DEC_BUFFER,
		BCGC_DEC_OTHER
	} bcgc_dec_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bcgc_req_t;

	typedef struct packed {
		logic main_en;
		logic sub_en;
		logic c2_en;
	} bcgc_chan_t;
endpackage : bcgc_pkg

//--- bcgc_regs.sv
// Buffer configuration and global control register bank with its gated outputs.
// Assumes synchronous inputs on mclk and a register master that never waits.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module bcgc_regs
	import bcgc_pkg::*;
(
	// Clock and reset.
	input  wire logic                   mclk,
	input  wire logic                   reset,
	// Register port.
	input  wire bcgc_pkg::bcgc_req_t    req,
	output logic [7:0]                  rdata,
	// Decoder side.
	input  wire bcgc_pkg::bcgc_dec_t    dec_mode,
	input  wire logic [7:0]             c2_flag_byte,
	input  wire logic                   c2_flag_valid,
	input  wire logic                   c2_flag_first,
	output logic [7:0]                  c2_summary,
	output bcgc_pkg::bcgc_chan_t        chan_en,
	output logic [11:0]                 block_size,
	output logic [2:0]                  dram_size,
	output logic [7:0]                  buffer_last_block_addr,
	output logic                        refresh_tick,
	// Global controls.
	output logic                        sleep_state,
	output logic                        soft_reset_pulse,
	output logic                        host_burst_length,
	output logic                        dsp_burst_length,
	output logic [2:0]                  arbiter_priority,
	// General pins and audio port.
	input  wire logic [3:0]             gp_out,
	input  wire logic [3:0]             gp_oe,
	input  wire logic                   audio_word_clock,
	input  wire logic                   audio_bit_clock,
	input  wire logic                   audio_serial_out,
	input  wire logic                   digital_audio_out,
	output logic [3:0]                  pin_out,
	output logic [3:0]                  pin_oe
);
	import bcgc_pkg::*;

	logic [7:0]  cfg_q;
	logic [7:0]  last_q;
	logic [7:0]  refresh_period_control;
	logic [7:0]  global_control_reg;
	logic [7:0]  acc_q;
	logic [15:0] ref_cnt_q;
	logic [15:0] ref_limit;
	logic        buf_mode;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	////////////////////////////////////////////////////////////////////////////
	// Register writes.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			cfg_q                  <= RST_BYTE;
			last_q                 <= RST_BYTE;
			refresh_period_control <= RST_BYTE;
			global_control_reg     <= RST_BYTE;
		end
		else if (req.wr)
		begin
			if (hit(req.addr, OFF_BUF_CFG))
				cfg_q <= req.wdata;
			if (hit(req.addr, OFF_LAST_BLK))
				last_q <= req.wdata;
			if (hit(req.addr, OFF_REFRESH))
				refresh_period_control <= req.wdata;
			if (hit(req.addr, OFF_GLOBAL))
				global_control_reg <= {req.wdata[7], 1'b0, req.wdata[5:0]};
		end
	end

	// Read data, one cycle after the strobe; others read zero.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			rdata <= RST_BYTE;
		else if (req.rd)
		begin
			case (req.addr)
				OFF_BUF_CFG:  rdata <= cfg_q;
				OFF_LAST_BLK: rdata <= last_q;
				OFF_REFRESH:  rdata <= refresh_period_control;
				OFF_GLOBAL:   rdata <= global_control_reg;
				default:      rdata <= RST_BYTE;
			endcase
		end
		else
			rdata <= RST_BYTE;
	end

	////////////////////////////////////////////////////////////////////////////
	// Soft reset pulse and static controls.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			soft_reset_pulse <= 1'b0;
		else
			soft_reset_pulse <= req.wr && hit(req.addr, OFF_GLOBAL) && req.wdata[BIT_SRST];
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			sleep_state            <= 1'b0;
			host_burst_length      <= 1'b0;
			dsp_burst_length       <= 1'b0;
			arbiter_priority       <= 3'h0;
			block_size             <= BLK_LARGE;
			dram_size              <= 3'h0;
			buffer_last_block_addr <= RST_BYTE;
		end
		else
		begin
			if (req.wr && hit(req.addr, OFF_GLOBAL))
				sleep_state <= req.wdata[BIT_SLEEP];
			host_burst_length      <= global_control_reg[BIT_HBURST];
			dsp_burst_length       <= global_control_reg[BIT_DBURST];
			arbiter_priority       <= global_control_reg[2:0];
			block_size             <= cfg_q[BIT_BLK] ? BLK_SMALL : BLK_LARGE;
			dram_size              <= cfg_q[2:0];
			buffer_last_block_addr <= last_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel enables, gated by decoder mode.
	assign buf_mode = (dec_mode == BCGC_DEC_BUFFER) || (dec_mode == BCGC_DEC_OTHER);

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			chan_en <= '0;
		else
		begin
			chan_en.main_en <= buf_mode && cfg_q[BIT_DSEL];
			chan_en.sub_en  <= buf_mode && cfg_q[BIT_SSEL];
			chan_en.c2_en   <= buf_mode && cfg_q[BIT_CSEL];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// C2 error summary accumulation.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			acc_q <= RST_BYTE;
		else if (c2_flag_valid)
		begin
			if (c2_flag_first)
				acc_q <= c2_flag_byte;
			else if (cfg_q[BIT_OR_FMT])
				acc_q <= acc_q | c2_flag_byte;
			else
				acc_q <= acc_q ^ c2_flag_byte;
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			c2_summary <= RST_BYTE;
		else
			c2_summary <= acc_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// Refresh interval divider.
	assign ref_limit = 16'(({8'h00, refresh_period_control} + 16'h0001) * {8'h00, REFRESH_UNIT});

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			ref_cnt_q    <= 16'h0000;
			refresh_tick <= 1'b0;
		end
		else if (sleep_state || ref_cnt_q >= 16'(ref_limit - 16'h0001))
		begin
			ref_cnt_q    <= 16'h0000;
			refresh_tick <= !sleep_state;
		end
		else
		begin
			ref_cnt_q    <= 16'(ref_cnt_q + 16'h0001);
			refresh_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// General pin mux.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			pin_out <= 4'h0;
			pin_oe  <= 4'h0;
		end
		else if (global_control_reg[BIT_AUDIO_PORT])
		begin
			pin_out <= {digital_audio_out, audio_serial_out, audio_bit_clock,
				audio_word_clock};
			pin_oe  <= 4'hF;
		end
		else
		begin
			pin_out <= gp_out;
			pin_oe  <= gp_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions.
	soft_reset_pulse_a: assert property (@(posedge mclk) disable iff (reset)
		(req.wr && req.addr == OFF_GLOBAL && req.wdata[BIT_SRST]) |=> soft_reset_pulse)
		else $error("soft reset write gave no pulse");
	soft_reset_once_a: assert property (@(posedge mclk) disable iff (reset)
		!(req.wr && req.addr == OFF_GLOBAL && req.wdata[BIT_SRST]) |=> !soft_reset_pulse)
		else $error("soft reset pulse without a write");
	sleep_entry_a: assert property (@(posedge mclk) disable iff (reset)
		(req.wr && req.addr == OFF_GLOBAL) |=> sleep_state == $past(req.wdata[BIT_SLEEP]))
		else $error("sleep state mismatch");
	main_gate_a: assert property (@(posedge mclk) disable iff (reset)
		!cfg_q[BIT_DSEL] |=> !chan_en.main_en)
		else $error("main data buffered while deselected");
	sub_gate_a: assert property (@(posedge mclk) disable iff (reset)
		(cfg_q[BIT_SSEL] && buf_mode) |=> chan_en.sub_en)
		else $error("subcode not buffered");
	c2_gate_a: assert property (@(posedge mclk) disable iff (reset)
		(dec_mode == BCGC_DEC_STOP) |=> !chan_en.c2_en)
		else $error("C2 flags stored in stop mode");
	block_size_a: assert property (@(posedge mclk) disable iff (reset)
		cfg_q[BIT_BLK] |=> block_size == 12'hA00)
		else $error("block size wrong");
	or_format_a: assert property (@(posedge mclk) disable iff (reset)
		(c2_flag_valid && !c2_flag_first && cfg_q[BIT_OR_FMT]) |=> (acc_q & $past(c2_flag_byte)) == $past(c2_flag_byte))
		else $error("OR summary lost bits");
	audio_pins_a: assert property (@(posedge mclk) disable iff (reset)
		global_control_reg[BIT_AUDIO_PORT] |=> (pin_oe == 4'hF && pin_out[0] == $past(audio_word_clock)))
		else $error("audio pin mux wrong");
	reserved_read_a: assert property (@(posedge mclk) disable iff (reset)
		(req.rd && (req.addr == OFF_RSVD_LOW || req.addr == OFF_RSVD_HIGH))
		|=> rdata == 8'h00)
		else $error("reserved register nonzero");
	first_load_a: assert property (@(posedge mclk) disable iff (reset)
		(c2_flag_valid && c2_flag_first) |=> acc_q == $past(c2_flag_byte))
		else $error("C2 summary did not restart on first byte");
	xor_format_a: assert property (@(posedge mclk) disable iff (reset)
		(c2_flag_valid && !c2_flag_first && !cfg_q[BIT_OR_FMT])
		|=> acc_q == ($past(acc_q) ^ $past(c2_flag_byte)))
		else $error("XOR summary wrong");
	summary_out_a: assert property (@(posedge mclk) disable iff (reset)
		1'b1 |=> c2_summary == $past(acc_q))
		else $error("C2 summary output wrong");
	main_mode_a: assert property (@(posedge mclk) disable iff (reset)
		!buf_mode |=> chan_en == '0)
		else $error("channel enabled outside buffering modes");
	c2_select_a: assert property (@(posedge mclk) disable iff (reset)
		(cfg_q[BIT_CSEL] && buf_mode) |=> chan_en.c2_en)
		else $error("C2 flags not stored");
	main_select_a: assert property (@(posedge mclk) disable iff (reset)
		(cfg_q[BIT_DSEL] && buf_mode) |=> chan_en.main_en)
		else $error("main data not buffered");
	block_large_a: assert property (@(posedge mclk) disable iff (reset)
		!cfg_q[BIT_BLK] |=> block_size == BLK_LARGE)
		else $error("large block size wrong");
	dram_size_a: assert property (@(posedge mclk) disable iff (reset)
		1'b1 |=> dram_size == $past(cfg_q[2:0]))
		else $error("DRAM size field wrong");
	last_block_a: assert property (@(posedge mclk) disable iff (reset)
		1'b1 |=> buffer_last_block_addr == $past(last_q))
		else $error("last block address wrong");
	tick_sleep_a: assert property (@(posedge mclk) disable iff (reset)
		sleep_state |=> !refresh_tick)
		else $error("refresh tick while asleep");
	tick_single_a: assert property (@(posedge mclk) disable iff (reset)
		refresh_tick |=> !refresh_tick)
		else $error("refresh tick longer than one cycle");
	sleep_hold_a: assert property (@(posedge mclk) disable iff (reset)
		!(req.wr && req.addr == OFF_GLOBAL) |=> sleep_state == $past(sleep_state))
		else $error("sleep state changed without a write");
	host_burst_a: assert property (@(posedge mclk) disable iff (reset)
		1'b1 |=> host_burst_length == $past(global_control_reg[BIT_HBURST]))
		else $error("host burst length wrong");
	dsp_burst_a: assert property (@(posedge mclk) disable iff (reset)
		1'b1 |=> dsp_burst_length == $past(global_control_reg[BIT_DBURST]))
		else $error("input burst length wrong");
	arbiter_a: assert property (@(posedge mclk) disable iff (reset)
		1'b1 |=> arbiter_priority == $past(global_control_reg[2:0]))
		else $error("arbiter priority wrong");
	gp_pass_a: assert property (@(posedge mclk) disable iff (reset)
		!global_control_reg[BIT_AUDIO_PORT]
		|=> (pin_out == $past(gp_out) && pin_oe == $past(gp_oe)))
		else $error("general pins not passed through");
	pin_audio_all_a: assert property (@(posedge mclk) disable iff (reset)
		global_control_reg[BIT_AUDIO_PORT] |=> pin_out == $past({digital_audio_out,
		audio_serial_out, audio_bit_clock, audio_word_clock}))
		else $error("audio pin order wrong");
	srst_read_a: assert property (@(posedge mclk) disable iff (reset)
		(req.rd && req.addr == OFF_GLOBAL) |=> !rdata[BIT_SRST])
		else $error("soft reset bit read back as one");
	rdata_idle_a: assert property (@(posedge mclk) disable iff (reset)
		!req.rd |=> rdata == 8'h00)
		else $error("read data not zero when idle");
	cfg_read_a: assert property (@(posedge mclk) disable iff (reset)
		(req.rd && req.addr == OFF_BUF_CFG) |=> rdata == $past(cfg_q))
		else $error("configuration readback wrong");
	last_read_a: assert property (@(posedge mclk) disable iff (reset)
		(req.rd && req.addr == OFF_LAST_BLK) |=> rdata == $past(last_q))
		else $error("last block readback wrong");
	refresh_read_a: assert property (@(posedge mclk) disable iff (reset)
		(req.rd && req.addr == OFF_REFRESH) |=> rdata == $past(refresh_period_control))
		else $error("refresh readback wrong");

	////////////////////////////////////////////////////////////////////////////
	// Cover properties.
	refresh_tick_c: cover property (@(posedge mclk) disable iff (reset) refresh_tick);
	sleep_c: cover property (@(posedge mclk) disable iff (reset) $rose(sleep_state));
	audio_c: cover property (@(posedge mclk) disable iff (reset)
		global_control_reg[BIT_AUDIO_PORT]);
	soft_reset_c: cover property (@(posedge mclk) disable iff (reset) soft_reset_pulse);
	or_format_c: cover property (@(posedge mclk) disable iff (reset)
		c2_flag_valid && !c2_flag_first && cfg_q[BIT_OR_FMT]);
endmodule : bcgc_regs

//--- bcgc_tb.sv
// Self-checking bench for the buffer configuration and global control bank.
// Assumes bcgc_pkg and bcgc_regs are compiled first; mclk runs at 100 MHz.
`timescale 1ns/10ps
module tb;
	import bcgc_pkg::*;
	logic               mclk      = 1'b0;
	logic               reset     = 1'b1;
	bcgc_req_t          req       = '0;
	bcgc_dec_t          dec_mode  = BCGC_DEC_STOP;
	logic [7:0]         c2b       = 8'h00;
	logic               c2v       = 1'b0;
	logic               c2f       = 1'b0;
	logic [3:0]         gpo       = 4'h0;
	logic [3:0]         gpe       = 4'h0;
	logic [3:0]         aud       = 4'h0;
	logic [7:0]         rdata, c2_summary, blast;
	bcgc_chan_t         chan_en;
	logic [11:0]        block_size;
	logic [2:0]         dram_size, arb;
	logic               tick, sleep, srst, hb, db;
	logic [3:0]         pin_out, pin_oe;
	int                 mismatches = 0;
	int                 num_checks = 0;
	logic [31:0]        seed       = 32'h37D7AC24;
	logic [7:0]         mdl [8'h2A:8'h2F] = '{default: 8'h00};

	bcgc_regs dut (.mclk(mclk), .reset(reset), .req(req), .rdata(rdata), .dec_mode(dec_mode),
		.c2_flag_byte(c2b), .c2_flag_valid(c2v), .c2_flag_first(c2f), .c2_summary(c2_summary),
		.chan_en(chan_en), .block_size(block_size), .dram_size(dram_size),
		.buffer_last_block_addr(blast), .refresh_tick(tick), .sleep_state(sleep),
		.soft_reset_pulse(srst), .host_burst_length(hb), .dsp_burst_length(db),
		.arbiter_priority(arb), .gp_out(gpo), .gp_oe(gpe), .audio_word_clock(aud[0]),
		.audio_bit_clock(aud[1]), .audio_serial_out(aud[2]), .digital_audio_out(aud[3]),
		.pin_out(pin_out), .pin_oe(pin_oe));

	always #5 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		rnd = seed[7:0];
	endfunction : rnd

	function automatic logic [7:0] gcr_val();
		logic [7:0] r;
		r = rnd();
		gcr_val = (r & 8'h88) | (r[0] ? 8'h14 : 8'h00);
	endfunction : gcr_val

	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic stop_test();
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		req.wr <= 1'b0;
		if (a == OFF_BUF_CFG || a == OFF_LAST_BLK || a == OFF_REFRESH)
			mdl[a] = d;
		else if (a == OFF_GLOBAL)
			mdl[a] = d & 8'hBF;
	endtask : wr

	task automatic rdchk(input logic [7:0] a);
		logic [7:0] e;
		e = (a >= 8'h2A && a <= 8'h2F) ? mdl[a] : 8'h00;
		@(posedge mclk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		req.rd <= 1'b0;
		@(negedge mclk);
		chk("rdata", e, rdata);
	endtask : rdchk

	task automatic cfgchk();
		logic [7:0] c;
		c = mdl[OFF_BUF_CFG];
		for (int m = 0; m < 4; m++)
		begin
			if (m < 3 || c[6])
			begin
				@(posedge mclk);
				dec_mode <= bcgc_dec_t'(m);
				repeat (3) @(posedge mclk);
				@(negedge mclk);
				chk("chan_en", (m >= 2) ? c[6:4] : 3'b000, chan_en);
			end
		end
		@(posedge mclk);
		dec_mode <= BCGC_DEC_STOP;
		chk("block_size", c[3] ? 12'hA00 : 12'hC00, block_size);
		chk("dram_size", c[2:0], dram_size);
		chk("last_block", mdl[OFF_LAST_BLK], blast);
	endtask : cfgchk

	task automatic gcrchk();
		logic [7:0] g, v, w;
		g = mdl[OFF_GLOBAL];
		v = rnd();
		w = rnd();
		@(posedge mclk);
		gpo <= v[3:0];
		gpe <= v[7:4];
		aud <= w[3:0];
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		chk("sleep", g[7], sleep);
		chk("host_burst", g[5], hb);
		chk("dsp_burst", g[4], db);
		chk("arbiter", g[2:0], arb);
		chk("pin_out", g[3] ? w[3:0] : v[3:0], pin_out);
		chk("pin_oe", g[3] ? 4'hF : v[7:4], pin_oe);
	endtask : gcrchk
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#200000;
		mismatches++;
		stop_test();
	end

	initial
	begin
		logic [7:0] a, v, e;
		int t, n;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		@(negedge mclk);
		chk("block_size", 12'hC00, block_size);
		chk("chan_en", 3'b000, chan_en);
		chk("sleep", 1'b0, sleep);
		for (a = 8'h28; a <= 8'h31; a++)
			rdchk(a);
		repeat (12)
		begin
			for (a = 8'h28; a <= 8'h31; a++)
				wr(a, (a == OFF_GLOBAL) ? gcr_val() : rnd());
			for (a = 8'h28; a <= 8'h31; a++)
				rdchk(a);
			cfgchk();
			gcrchk();
		end
		for (int f = 0; f < 2; f++)
		begin
			wr(OFF_BUF_CFG, {f[0], 7'h00});
			e = 8'h00;
			for (int k = 0; k < 6; k++)
			begin
				v = rnd();
				@(posedge mclk);
				c2b <= v;
				c2v <= 1'b1;
				c2f <= (k == 0);
				e = (k == 0) ? v : (f == 1) ? (e | v) : (e ^ v);
			end
			@(posedge mclk);
			c2v <= 1'b0;
			c2f <= 1'b0;
			repeat (2) @(posedge mclk);
			@(negedge mclk);
			chk("c2_summary", e, c2_summary);
		end
		wr(OFF_GLOBAL, 8'h40);
		@(negedge mclk);
		chk("soft_reset", 1'b1, srst);
		@(negedge mclk);
		chk("soft_reset", 1'b0, srst);
		rdchk(OFF_GLOBAL);
		wr(OFF_GLOBAL, 8'h80);
		@(negedge mclk);
		chk("sleep", 1'b1, sleep);
		wr(OFF_REFRESH, 8'h02);
		n = 0;
		repeat (100) @(negedge mclk) n += (tick === 1'b1);
		chk("tick_asleep", 12'h000, n[11:0]);
		wr(OFF_GLOBAL, 8'h00);
		t = 0;
		while (tick !== 1'b1 && t < 5000) @(negedge mclk) t++;
		t = 0;
		do @(negedge mclk) t++; while (tick !== 1'b1 && t < 200);
		chk("refresh_gap", 12'd48, t[11:0]);
		stop_test();
	end
endmodule : tb
